// ---- rtl/dtf_report_framer.sv ----
// digitizer touch report framer: queues touches, builds 18-byte reports for the host
// assumes touch/config inputs on i_ref_clk, host requests on i_link_clk, shared async reset
`include "dtf_map.svh"
`timescale 1ns/1ns
`default_nettype none

module dtf_report_framer
	import dtf_pkg::*;
#(
	parameter int QUEUE_DEPTH = `DTF_QUEUE_DEPTH,
	parameter int POS_W = `DTF_POS_W,
	parameter int TS_DIV = `DTF_TS_PERIOD_NS / `DTF_CLK_PERIOD_NS
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_link_clk,
	input wire logic i_touch_valid,
	input wire logic i_touch_first,
	input wire logic [7:0] i_touch_pkg_count,
	input wire logic i_touch_status,
	input wire logic [7:0] i_touch_index,
	input wire logic [POS_W-1:0] i_touch_x,
	input wire logic [POS_W-1:0] i_touch_cx,
	input wire logic [POS_W-1:0] i_touch_y,
	input wire logic [POS_W-1:0] i_touch_cy,
	input wire logic [7:0] i_touch_width,
	input wire logic [7:0] i_touch_height,
	output logic o_touch_ready,
	input wire logic i_geometry_report_enable,
	input wire logic [7:0] i_tracked_touch_limit,
	input wire logic i_quality_valid,
	input wire logic [8*(`DTF_PKT_BYTES-1)-1:0] i_quality_payload,
	input wire logic i_link_get,
	input wire dtf_req_t i_link_get_kind,
	input wire logic [7:0] i_link_get_arg,
	input wire logic [4:0] i_link_rd_idx,
	output logic o_link_ready,
	output logic [7:0] o_link_byte,
	output logic o_report_pending_n,
	output logic o_low_power,
	output logic [7:0] o_max_touches
);
	localparam int AW = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
	localparam int EW = $bits(dtf_touch_t);
	localparam int TSW = $clog2(TS_DIV + 1);

	generate
		if (QUEUE_DEPTH < 2 || POS_W < `DTF_COORD_W || TS_DIV < 1) begin : g_bad_param
			$error("dtf_report_framer: unsupported parameter value");
		end
	endgenerate

	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		next_ptr = (p == AW'(QUEUE_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : next_ptr

	// keep the top 12 bits of a wider coordinate
	function automatic logic [`DTF_COORD_W-1:0] scale_pos(input logic [POS_W-1:0] v);
		scale_pos = v[POS_W-1 -: `DTF_COORD_W];
	endfunction : scale_pos

	function automatic logic [`DTF_PKT_W-1:0] build_touch(input dtf_touch_t e, input logic geom);
		logic [`DTF_PKT_W-1:0] p;
		p = '0;
		p[`DTF_B_REPORT_IDENTIFIER*8 +: 8] = `DTF_TOUCH_REPORT_IDENTIFIER;
		p[`DTF_B_STATUS*8] = e.status;
		p[`DTF_B_TOUCH_ID*8 +: 8] = e.id;
		p[`DTF_B_X*8 +: 12] = e.x;
		p[`DTF_B_Y*8 +: 12] = e.y;
		if (geom) begin
			p[`DTF_B_CX*8 +: 12] = e.cx;
			p[`DTF_B_CY*8 +: 12] = e.cy;
			p[`DTF_B_WIDTH*8 +: 8] = e.width;
			p[`DTF_B_HEIGHT*8 +: 8] = e.height;
		end
		p[`DTF_B_TS*8 +: 16] = e.ts;
		p[`DTF_B_COUNT*8 +: 8] = e.count;
		build_touch = p;
	endfunction : build_touch

	dtf_xfer_if xf ();

	// link domain end
	dtf_link_port u_link (
		.i_link_clk(i_link_clk),
		.i_arst_n(i_arst_n),
		.xf(xf.link),
		.i_get(i_link_get),
		.i_get_kind(i_link_get_kind),
		.i_get_arg(i_link_get_arg),
		.i_rd_idx(i_link_rd_idx),
		.o_ready(o_link_ready),
		.o_byte(o_link_byte)
	);

	// request toggle arrives from the link clock
	logic req_s1;
	logic req_s2;
	logic req_seen;
	logic req_edge;

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_seen <= 1'b0;
		end else begin
			req_s1 <= xf.req_tgl;
			req_s2 <= req_s1;
			req_seen <= req_s2;
		end
	end

	assign req_edge = req_s2 ^ req_seen;

	// 10 kHz scan timestamp
	logic [TSW-1:0] ts_div;
	logic [15:0] ts_count;

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ts_div <= '0;
			ts_count <= 16'h0000;
		end else if (ts_div == TSW'(TS_DIV - 1)) begin
			ts_div <= '0;
			ts_count <= ts_count + 16'h0001;
		end else begin
			ts_div <= ts_div + 1'b1;
		end
	end

	// touch queue
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] q_count;
	logic [AW:0] next_q_count;
	logic [7:0] pkg_seen;
	logic take;
	logic keep;
	logic push;
	logic pop;
	dtf_touch_t new_entry;
	dtf_touch_t rd_entry;
	dtf_state_t state;
	logic [7:0] max_touches;

	assign take = i_touch_valid && o_touch_ready;
	// touches beyond the reportable limit inside one package are dropped
	assign keep = i_touch_first || (pkg_seen < max_touches);
	assign push = take && keep;
	assign pop = (state == DTF_FETCH);

	always_comb begin
		new_entry.status = i_touch_status;
		new_entry.id = i_touch_index;
		new_entry.x = scale_pos(i_touch_x);
		new_entry.cx = scale_pos(i_touch_cx);
		new_entry.y = scale_pos(i_touch_y);
		new_entry.cy = scale_pos(i_touch_cy);
		new_entry.width = i_touch_width;
		new_entry.height = i_touch_height;
		new_entry.ts = ts_count;
		if (i_touch_first) begin
			new_entry.count = (i_touch_pkg_count > max_touches) ? max_touches
				: i_touch_pkg_count;
		end else begin
			new_entry.count = 8'h00;
		end
	end

	always_comb begin
		next_q_count = q_count;
		if (push && !pop) begin
			next_q_count = q_count + 1'b1;
		end else if (pop && !push) begin
			next_q_count = q_count - 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			q_count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= next_ptr(wr_ptr);
			end
			if (pop) begin
				rd_ptr <= next_ptr(rd_ptr);
			end
			q_count <= next_q_count;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pkg_seen <= 8'h00;
		end else if (take && i_touch_first) begin
			pkg_seen <= 8'h01;
		end else if (take && pkg_seen != 8'hFF) begin
			pkg_seen <= pkg_seen + 8'h01;
		end
	end

	// no new touches while asleep or full
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_touch_ready <= 1'b0;
		end else begin
			o_touch_ready <= !o_low_power && (next_q_count < (AW + 1)'(QUEUE_DEPTH));
		end
	end

	dtf_touch_mem #(
		.W(EW),
		.DEPTH(QUEUE_DEPTH),
		.AW(AW)
	) u_mem (
		.i_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_we(push),
		.i_waddr(wr_ptr),
		.i_wdata(new_entry),
		.i_re(pop),
		.i_raddr(rd_ptr),
		.o_rdata(rd_entry)
	);

	// quality payload latched from the local side
	logic [8*(`DTF_PKT_BYTES-1)-1:0] qual_data;
	logic qual_pending;
	logic qual_taken;

	assign qual_taken = (state == DTF_IDLE) && req_edge && (xf.req_kind == DTF_REQ_QUALITY);

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			qual_data <= '0;
			qual_pending <= 1'b0;
		end else if (i_quality_valid) begin
			qual_data <= i_quality_payload;
			qual_pending <= 1'b1;
		end else if (qual_taken) begin
			qual_pending <= 1'b0;
		end
	end

	// report builder and answer sequencing
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= DTF_IDLE;
			xf.packet <= '0;
			xf.ack_tgl <= 1'b0;
		end else begin
			case (state)
				DTF_IDLE: begin
					if (req_edge) begin
						state <= DTF_ANSWER;
						case (xf.req_kind)
							DTF_REQ_TOUCH: begin
								if (q_count != '0) begin
									state <= DTF_FETCH;
								end else begin
									xf.packet <= build_touch('{ts: ts_count, default: '0},
										i_geometry_report_enable);
								end
							end
							DTF_REQ_MAX_RD, DTF_REQ_MAX_WR: begin
								xf.packet <= '0;
								xf.packet[`DTF_B_REPORT_IDENTIFIER*8 +: 8] <= `DTF_MAX_REPORT_IDENTIFIER;
								xf.packet[`DTF_B_MAX*8 +: 8] <= next_max();
							end
							DTF_REQ_QUALITY: begin
								xf.packet[`DTF_B_REPORT_IDENTIFIER*8 +: 8] <= `DTF_QUAL_REPORT_IDENTIFIER;
								xf.packet[`DTF_B_PAYLOAD*8 +: 8*(`DTF_PKT_BYTES-1)] <= qual_data;
							end
							default: begin
								xf.packet <= '0;
							end
						endcase
					end
				end
				DTF_FETCH: begin
					state <= DTF_LOAD;
				end
				DTF_LOAD: begin
					xf.packet <= build_touch(rd_entry, i_geometry_report_enable);
					state <= DTF_ANSWER;
				end
				DTF_ANSWER: begin
					xf.ack_tgl <= ~xf.ack_tgl;
					state <= DTF_IDLE;
				end
				default: begin
					state <= DTF_IDLE;
				end
			endcase
		end
	end

	// value the limit holds after this cycle's request
	function automatic logic [7:0] next_max();
		if (xf.req_kind == DTF_REQ_MAX_WR && xf.req_arg <= i_tracked_touch_limit) begin
			next_max = xf.req_arg;
		end else begin
			next_max = max_touches;
		end
	endfunction : next_max

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			max_touches <= `DTF_MAX_TOUCH_RST;
		end else if (state == DTF_IDLE && req_edge) begin
			max_touches <= next_max();
		end
	end

	assign o_max_touches = max_touches;

	// SET POWER: argument bit 0 set means sleep, clear means on
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_low_power <= 1'b0;
		end else if (state == DTF_IDLE && req_edge && xf.req_kind == DTF_REQ_POWER) begin
			o_low_power <= xf.req_arg[0];
		end
	end

	// low while a touch or quality report waits
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_report_pending_n <= 1'b1;
		end else begin
			o_report_pending_n <= !((next_q_count != '0) || i_quality_valid
				|| (qual_pending && !qual_taken));
		end
	end
endmodule : dtf_report_framer

`default_nettype wire

// ---- common/dtf_map.svh ----
// constants of the digitizer touch report framer: byte slots, ids, timing
// assumes nothing; included by package, interface and design files
`ifndef DTF_MAP_SVH
`define DTF_MAP_SVH

`define DTF_PKT_BYTES 18
`define DTF_PKT_W 144
`define DTF_COORD_W 12
`define DTF_QUEUE_DEPTH 16
`define DTF_POS_W 12

// byte slots inside an 18-byte report
`define DTF_B_REPORT_IDENTIFIER 0
`define DTF_B_STATUS 1
`define DTF_B_TOUCH_ID 2
`define DTF_B_X 3
`define DTF_B_CX 5
`define DTF_B_Y 7
`define DTF_B_CY 9
`define DTF_B_WIDTH 11
`define DTF_B_HEIGHT 13
`define DTF_B_TS 15
`define DTF_B_COUNT 17
`define DTF_B_MAX 1
`define DTF_B_PAYLOAD 1

// report identifiers and reset value of the touch limit (arbitrary values)
`define DTF_TOUCH_REPORT_IDENTIFIER 8'h01
`define DTF_MAX_REPORT_IDENTIFIER 8'h02
`define DTF_QUAL_REPORT_IDENTIFIER 8'h05
`define DTF_MAX_TOUCH_RST 8'h0A

// timestamp tick of 10 kHz on the 125 MHz reference clock
`define DTF_TS_PERIOD_NS 100000
`define DTF_CLK_PERIOD_NS 8

`endif

// ---- common/dtf_pkg.sv ----
// types shared by the digitizer touch report framer
// assumes dtf_map.svh on the include path
`include "dtf_map.svh"

package dtf_pkg;

	typedef enum logic [2:0] {
		DTF_REQ_TOUCH,
		DTF_REQ_MAX_RD,
		DTF_REQ_MAX_WR,
		DTF_REQ_QUALITY,
		DTF_REQ_POWER
	} dtf_req_t;

	typedef struct packed {
		logic status;
		logic [7:0] id;
		logic [`DTF_COORD_W-1:0] x;
		logic [`DTF_COORD_W-1:0] cx;
		logic [`DTF_COORD_W-1:0] y;
		logic [`DTF_COORD_W-1:0] cy;
		logic [7:0] width;
		logic [7:0] height;
		logic [15:0] ts;
		logic [7:0] count;
	} dtf_touch_t;

	typedef enum logic [1:0] {
		DTF_IDLE,
		DTF_FETCH,
		DTF_LOAD,
		DTF_ANSWER
	} dtf_state_t;

endpackage : dtf_pkg

// ---- common/dtf_xfer_if.sv ----
// request/answer crossing between reference-clock and link-clock logic
// req side toggles req_tgl with kind/arg held; answer toggles ack_tgl after packet settles
`include "dtf_map.svh"
`timescale 1ns/1ns
`default_nettype none

interface dtf_xfer_if;
	import dtf_pkg::*;
	logic req_tgl;
	dtf_req_t req_kind;
	logic [7:0] req_arg;
	logic ack_tgl;
	logic [`DTF_PKT_W-1:0] packet;
	modport sys(input req_tgl, input req_kind, input req_arg, output ack_tgl, output packet);
	modport link(output req_tgl, output req_kind, output req_arg, input ack_tgl, input packet);
endinterface : dtf_xfer_if

`default_nettype wire

// ---- rtl/dtf_touch_mem.sv ----
// touch entry store of the report queue, one write and one registered read port
// assumes a single clock; contents are not reset
`timescale 1ns/1ns
`default_nettype none

module dtf_touch_mem #(
	parameter int W = 97,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [W-1:0] i_wdata,
	input wire logic i_re,
	input wire logic [AW-1:0] i_raddr,
	output logic [W-1:0] o_rdata
);
	logic [W-1:0] mem [DEPTH];

	generate
		if (DEPTH < 1 || DEPTH > (1 << AW) || W < 1) begin : g_bad_param
			$error("dtf_touch_mem: depth does not fit the address width");
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata <= '0;
		end else if (i_re) begin
			o_rdata <= mem[i_raddr];
		end
	end
endmodule : dtf_touch_mem

`default_nettype wire

// ---- rtl/dtf_link_port.sv ----
// link-clock end: takes host report requests, hands them across, serves packet bytes
// assumes the sys end holds packet stable from its ack toggle until the next request
`include "dtf_map.svh"
`timescale 1ns/1ns
`default_nettype none

module dtf_link_port
	import dtf_pkg::*;
(
	input wire logic i_link_clk,
	input wire logic i_arst_n,
	dtf_xfer_if.link xf,
	input wire logic i_get,
	input wire dtf_req_t i_get_kind,
	input wire logic [7:0] i_get_arg,
	input wire logic [4:0] i_rd_idx,
	output logic o_ready,
	output logic [7:0] o_byte
);
	logic ack_s1;
	logic ack_s2;
	logic ack_seen;
	logic [`DTF_PKT_W-1:0] pkt;

	always_ff @(posedge i_link_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			ack_seen <= 1'b0;
		end else begin
			ack_s1 <= xf.ack_tgl;
			ack_s2 <= ack_s1;
			ack_seen <= ack_s2;
		end
	end

	// one request in flight; kind and argument stay put until the answer
	always_ff @(posedge i_link_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			xf.req_tgl <= 1'b0;
			xf.req_kind <= DTF_REQ_TOUCH;
			xf.req_arg <= 8'h00;
			o_ready <= 1'b1;
			pkt <= '0;
		end else if (o_ready && i_get) begin
			xf.req_tgl <= ~xf.req_tgl;
			xf.req_kind <= i_get_kind;
			xf.req_arg <= i_get_arg;
			o_ready <= 1'b0;
		end else if (!o_ready && (ack_s2 != ack_seen)) begin
			pkt <= xf.packet;
			o_ready <= 1'b1;
		end
	end

	always_ff @(posedge i_link_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_byte <= 8'h00;
		end else if (i_rd_idx < 5'(`DTF_PKT_BYTES)) begin
			o_byte <= pkt[i_rd_idx*8 +: 8];
		end else begin
			o_byte <= 8'h00;
		end
	end
endmodule : dtf_link_port

`default_nettype wire

// ---- sim/dtf_report_framer_chk.sv ----
// port checker of the report framer
// assumes it is bound onto dtf_report_framer
`timescale 1ns/1ns
`default_nettype none

module dtf_report_framer_chk (
	input wire logic i_ref_clk,
	input wire logic i_link_clk,
	input wire logic i_arst_n,
	input wire logic i_touch_valid,
	input wire logic o_touch_ready,
	input wire logic o_report_pending_n,
	input wire logic o_low_power,
	input wire logic [7:0] o_max_touches,
	input wire logic [7:0] i_tracked_touch_limit,
	input wire logic i_link_get,
	input wire logic o_link_ready,
	input wire logic [4:0] i_link_rd_idx,
	input wire logic [7:0] o_link_byte
);
	sequence s_take;
		i_link_get && o_link_ready;
	endsequence
	sequence s_turn;
		!o_link_ready ##[1:40] o_link_ready;
	endsequence
	pend_on_push_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_touch_valid && o_touch_ready |=> !o_report_pending_n) else $error("pending stays high");
	pend_rise_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		$rose(o_report_pending_n) |-> !o_link_ready && !$past(i_touch_valid && o_touch_ready))
		else $error("pending released without read");
	sleep_block_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		o_low_power [*3] |-> !o_touch_ready) else $error("touch taken in low power");
	link_turn_a: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		s_take |=> s_turn) else $error("request not answered in time");
	pad_zero_a: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		o_link_ready && !i_link_get && i_link_rd_idx > 5'h11 |=> o_link_byte == 8'h00)
		else $error("byte past packet not zero");
	limit_cap_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		$changed(o_max_touches) |-> o_max_touches <= i_tracked_touch_limit)
		else $error("limit above tracked count");
	limit_busy_a: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		$changed(o_max_touches) |-> !o_link_ready) else $error("limit changed without write");
	sleep_enter_a: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		$rose(o_low_power) |-> !o_link_ready) else $error("low power without command");
endmodule : dtf_report_framer_chk

bind dtf_report_framer dtf_report_framer_chk u_chk (.i_ref_clk, .i_link_clk, .i_arst_n,
	.i_touch_valid, .o_touch_ready, .o_report_pending_n, .o_low_power, .o_max_touches,
	.i_tracked_touch_limit, .i_link_get, .o_link_ready, .i_link_rd_idx, .o_link_byte);

`default_nettype wire

// ---- sim/dtf_host_model.sv ----
// host side of the link: issues report requests and reads answer bytes
// assumes ready/byte come from the framer's link port on i_link_clk
`timescale 1ns/1ns
`default_nettype none

module dtf_host_model import dtf_pkg::*; (
	input wire logic i_link_clk,
	input wire logic i_ready,
	input wire logic [7:0] i_byte,
	output logic o_get,
	output dtf_req_t o_kind,
	output logic [7:0] o_arg,
	output logic [4:0] o_idx
);
	initial begin
		o_get = 1'b0;
		o_kind = DTF_REQ_TOUCH;
		o_arg = 8'h00;
		o_idx = 5'h14;
	end
	// one request, then all 18 bytes; ok low on a hung answer
	task automatic fetch(input dtf_req_t k, input logic [7:0] a, output logic [143:0] p,
		output logic ok);
		int n;
		p = '0;
		n = 0;
		@(posedge i_link_clk);
		o_get <= 1'b1;
		o_kind <= k;
		o_arg <= a;
		do @(negedge i_link_clk); while (i_ready !== 1'b1);
		@(posedge i_link_clk);
		o_get <= 1'b0;
		do begin
			@(negedge i_link_clk);
			n++;
		end while (i_ready !== 1'b1 && n < 60);
		ok = n < 60;
		for (int i = 0; i < 18; i++) begin
			@(posedge i_link_clk);
			o_idx <= 5'(i);
			@(posedge i_link_clk);
			@(negedge i_link_clk);
			p[8*i+:8] = i_byte;
		end
		@(posedge i_link_clk);
		o_idx <= 5'h14;
	endtask : fetch
endmodule : dtf_host_model

`default_nettype wire

// ---- sim/dtf_report_framer_bench.sv ----
// self-checking bench of the report framer
// assumes the host model on the link side and a checker bound to the framer
`include "dtf_map.svh"
`timescale 1ns/1ns
`default_nettype none

module dtf_report_framer_bench import dtf_pkg::*;;
	localparam int TS = 4;
	logic i_ref_clk, i_link_clk, i_arst_n, i_touch_valid, i_touch_first, i_touch_status;
	logic o_touch_ready, i_geometry_report_enable, i_quality_valid, i_link_get, o_link_ready;
	logic o_report_pending_n, o_low_power;
	logic [7:0] i_touch_pkg_count, i_touch_index, i_touch_width, i_touch_height;
	logic [7:0] i_tracked_touch_limit, i_link_get_arg, o_link_byte, o_max_touches;
	logic [11:0] i_touch_x, i_touch_cx, i_touch_y, i_touch_cy;
	logic [135:0] i_quality_payload;
	logic [4:0] i_link_rd_idx;
	dtf_req_t i_link_get_kind;
	int bad_count, check_count;
	logic [143:0] pkt;
	time t_take;
	dtf_touch_t ta;

	dtf_report_framer #(.TS_DIV(TS)) u_dut (.i_ref_clk, .i_arst_n, .i_link_clk, .i_touch_valid,
		.i_touch_first, .i_touch_pkg_count, .i_touch_status, .i_touch_index, .i_touch_x,
		.i_touch_cx, .i_touch_y, .i_touch_cy, .i_touch_width, .i_touch_height, .o_touch_ready,
		.i_geometry_report_enable, .i_tracked_touch_limit, .i_quality_valid, .i_quality_payload,
		.i_link_get, .i_link_get_kind, .i_link_get_arg, .i_link_rd_idx, .o_link_ready,
		.o_link_byte, .o_report_pending_n, .o_low_power, .o_max_touches);
	dtf_host_model u_host (.i_link_clk, .i_ready(o_link_ready), .i_byte(o_link_byte),
		.o_get(i_link_get), .o_kind(i_link_get_kind), .o_arg(i_link_get_arg), .o_idx(i_link_rd_idx));

	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		i_link_clk = 1'b0;
		#2;
		forever #3 i_link_clk = ~i_link_clk;
	end

	task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : cmp8
	task automatic cmp_pkt(input string what, input logic [143:0] e, input logic [143:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_pkt
	function automatic logic [143:0] exp_touch(input dtf_touch_t t, input logic g,
		input logic [7:0] c);
		logic [143:0] p;
		p = '0;
		p[7:0] = `DTF_TOUCH_REPORT_IDENTIFIER;
		p[8] = t.status;
		p[23:16] = t.id;
		p[35:24] = t.x;
		p[67:56] = t.y;
		p[143:136] = c;
		if (g) begin
			p[51:40] = t.cx;
			p[83:72] = t.cy;
			p[95:88] = t.width;
			p[111:104] = t.height;
		end
		return p;
	endfunction : exp_touch
	// timestamp bytes blanked, they are judged apart
	function automatic logic [143:0] nots(input logic [143:0] p);
		return {p[143:136], 16'h0000, p[119:0]};
	endfunction : nots
	task automatic ask(input dtf_req_t k, input logic [7:0] a);
		logic ok;
		u_host.fetch(k, a, pkt, ok);
		cmp8("answer", 8'h01, 8'(ok));
	endtask : ask
	task automatic push(input dtf_touch_t t, input logic first, input logic [7:0] cnt);
		@(posedge i_ref_clk);
		i_touch_valid <= 1'b1;
		i_touch_first <= first;
		i_touch_pkg_count <= cnt;
		i_touch_status <= t.status;
		i_touch_index <= t.id;
		{i_touch_x, i_touch_cx, i_touch_y, i_touch_cy} <= {t.x, t.cx, t.y, t.cy};
		{i_touch_width, i_touch_height} <= {t.width, t.height};
		do @(negedge i_ref_clk); while (o_touch_ready !== 1'b1);
		@(posedge i_ref_clk);
		i_touch_valid <= 1'b0;
		t_take = $time;
	endtask : push
	task automatic pend(input logic [7:0] e);
		repeat (4) @(negedge i_ref_clk);
		cmp8("pending_n", e, 8'(o_report_pending_n));
	endtask : pend

	task automatic t_layout;
		for (int g = 0; g < 2; g++) begin
			@(posedge i_ref_clk);
			i_geometry_report_enable <= g[0];
			push(ta, 1'b1, 8'h01);
			pend(8'h00);
			ask(DTF_REQ_TOUCH, 8'h00);
			cmp_pkt("touch", exp_touch(ta, g[0], 8'h01), nots(pkt));
		end
		$display("test layout done");
	endtask : t_layout
	task automatic t_pkg;
		dtf_touch_t t[3];
		for (int i = 0; i < 3; i++) begin
			t[i] = ta;
			t[i].id = 8'(i);
			t[i].y = 12'h100 + 12'(i);
		end
		for (int i = 0; i < 3; i++) push(t[i], i == 0, 8'h03);
		for (int i = 0; i < 3; i++) begin
			ask(DTF_REQ_TOUCH, 8'h00);
			cmp_pkt("package", exp_touch(t[i], 1'b1, i == 0 ? 8'h03 : 8'h00), nots(pkt));
			if (i < 2) pend(8'h00);
		end
		pend(8'h01);
		ask(DTF_REQ_TOUCH, 8'h00);
		cmp8("idle status", 8'h00, pkt[15:8]);
		$display("test package done");
	endtask : t_pkg
	task automatic t_ts;
		time t0;
		int d, e;
		push(ta, 1'b1, 8'h01);
		t0 = t_take;
		repeat (40) @(posedge i_ref_clk);
		push(ta, 1'b1, 8'h01);
		e = int'((t_take - t0) / (`DTF_CLK_PERIOD_NS * TS));
		ask(DTF_REQ_TOUCH, 8'h00);
		d = int'(pkt[135:120]);
		ask(DTF_REQ_TOUCH, 8'h00);
		d = int'(pkt[135:120]) - d;
		cmp8("ts step", 8'h01, 8'(d >= e - 1 && d <= e + 1));
		$display("test timestamp done");
	endtask : t_ts
	task automatic t_max;
		ask(DTF_REQ_MAX_RD, 8'h00);
		cmp_pkt("max read", {128'h0, `DTF_MAX_TOUCH_RST, `DTF_MAX_REPORT_IDENTIFIER}, pkt);
		ask(DTF_REQ_MAX_WR, 8'h03);
		cmp_pkt("max write", {128'h0, 8'h03, `DTF_MAX_REPORT_IDENTIFIER}, pkt);
		ask(DTF_REQ_MAX_WR, 8'h09);
		cmp8("max refused", 8'h03, o_max_touches);
		for (int i = 0; i < 5; i++) push(ta, i == 0, 8'h05);
		ask(DTF_REQ_TOUCH, 8'h00);
		cmp8("clipped count", 8'h03, pkt[143:136]);
		repeat (3) ask(DTF_REQ_TOUCH, 8'h00);
		cmp8("dropped", 8'h00, pkt[15:8]);
		ask(DTF_REQ_MAX_WR, 8'h08);
		cmp8("max at limit", 8'h08, o_max_touches);
		$display("test max done");
	endtask : t_max
	task automatic t_quality;
		logic [135:0] q;
		q = {8'h11, {8{8'h9C, 8'h36}}};
		@(posedge i_ref_clk);
		i_quality_payload <= q;
		i_quality_valid <= 1'b1;
		@(posedge i_ref_clk);
		i_quality_valid <= 1'b0;
		pend(8'h00);
		ask(DTF_REQ_QUALITY, 8'h00);
		cmp_pkt("quality", {q, `DTF_QUAL_REPORT_IDENTIFIER}, pkt);
		pend(8'h01);
		$display("test quality done");
	endtask : t_quality
	task automatic t_power;
		for (int s = 1; s >= 0; s--) begin
			ask(DTF_REQ_POWER, 8'(s));
			pend(8'h01);
			cmp8("low power", 8'(s), 8'(o_low_power));
			cmp8("touch ready", 8'(1 - s), 8'(o_touch_ready));
			cmp_pkt("power answer", 144'h0, pkt);
		end
		$display("test power done");
	endtask : t_power

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (30000) @(posedge i_ref_clk);
		bad_count++;
		$display("[ERR] run expected end seen hang");
		wrap_up;
	end
	initial begin
		i_arst_n = 1'b0;
		{i_touch_valid, i_touch_first, i_touch_status, i_quality_valid} = '0;
		{i_touch_pkg_count, i_touch_index, i_touch_width, i_touch_height} = '0;
		{i_touch_x, i_touch_cx, i_touch_y, i_touch_cy, i_quality_payload} = '0;
		i_geometry_report_enable = 1'b1;
		i_tracked_touch_limit = 8'h08;
		ta = {1'b1, 8'h05, 12'hABC, 12'h5A3, 12'h3D7, 12'hC21, 8'h9E, 8'h47, 16'h0000, 8'h00};
		repeat (8) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		t_layout;
		t_pkg;
		t_ts;
		t_max;
		t_quality;
		t_power;
		wrap_up;
	end
endmodule : dtf_report_framer_bench

`default_nettype wire
